// ### verilog/amid_defs.svh
`ifndef AMID_DEFS_SVH
`define AMID_DEFS_SVH

// ======================================================================
// Register offsets (byte addresses)
`define AMID_OFS_ID0 12'hFF0
`define AMID_OFS_ID1 12'hFF4
`define AMID_OFS_ID2 12'hFF8
`define AMID_OFS_ID3 12'hFFC
`define AMID_OFS_CTRL 12'hF00
`define AMID_OFS_STAT 12'hF04

// ======================================================================
// Identification field values
`define AMID_PREAMBLE0 8'h0D
`define AMID_CLASS 4'h9
`define AMID_PREAMBLE_LOW 4'h0
`define AMID_PREAMBLE2 8'h05
`define AMID_PREAMBLE3 8'hB1
`define AMID_RSVD_ZERO 24'h000000

// ======================================================================
// Field positions and reset values
`define AMID_CLASS_MSB 7
`define AMID_CLASS_LSB 4
`define AMID_CTRL_CLR_BIT 0
`define AMID_CTRL_EN_BIT 1
`define AMID_CTRL_RST 2'h2
`define AMID_STAT_LAST_BIT 16
`define AMID_CNT_RST 16'h0000
`define AMID_CNT_MAX 16'hFFFF
`define AMID_WORD_ZERO 32'h00000000

`endif

// ### verilog/amid_pkg.sv
package amid_pkg;
  typedef logic [11:0] amid_addr_t;
  typedef logic [31:0] amid_word_t;
  typedef logic [15:0] amid_cnt_t;
  typedef enum logic [2:0] {
    AMID_SEL_NONE,
    AMID_SEL_ID0,
    AMID_SEL_ID1,
    AMID_SEL_ID2,
    AMID_SEL_ID3,
    AMID_SEL_CTRL,
    AMID_SEL_STAT
  } amid_sel_t;
endpackage

// ### verilog/amid_dec_if.sv
`timescale 1ns/10ps
interface amid_dec_if;
  import amid_pkg::*;
  amid_addr_t addr;
  amid_sel_t sel;
  logic id_hit;
  amid_word_t id_word;
  modport rom (input addr, output sel, output id_hit, output id_word);
  modport user (output addr, input sel, input id_hit, input id_word);
endinterface

// ### verilog/amid_id_rom.sv
`timescale 1ns/10ps
`include "amid_defs.svh"
module amid_id_rom (
  amid_dec_if.rom dec
);
  import amid_pkg::*;

  // ====================================================================
  // Address decode and constant words
  // Pure constants: nothing here can be altered by any bus write
  // constant words, upper zero
  always_comb begin
    dec.sel = AMID_SEL_NONE;
    dec.id_hit = 1'b0;
    dec.id_word = `AMID_WORD_ZERO;
    unique case (dec.addr)
      `AMID_OFS_ID0: begin
        dec.sel = AMID_SEL_ID0;
        dec.id_hit = 1'b1;
        dec.id_word = {`AMID_RSVD_ZERO, `AMID_PREAMBLE0};
      end
      `AMID_OFS_ID1: begin
        dec.sel = AMID_SEL_ID1;
        dec.id_hit = 1'b1;
        dec.id_word = {`AMID_RSVD_ZERO, `AMID_CLASS, `AMID_PREAMBLE_LOW};
      end
      `AMID_OFS_ID2: begin
        dec.sel = AMID_SEL_ID2;
        dec.id_hit = 1'b1;
        dec.id_word = {`AMID_RSVD_ZERO, `AMID_PREAMBLE2};
      end
      `AMID_OFS_ID3: begin
        dec.sel = AMID_SEL_ID3;
        dec.id_hit = 1'b1;
        dec.id_word = {`AMID_RSVD_ZERO, `AMID_PREAMBLE3};
      end
      `AMID_OFS_CTRL: begin
        dec.sel = AMID_SEL_CTRL;
      end
      `AMID_OFS_STAT: begin
        dec.sel = AMID_SEL_STAT;
      end
      default: begin
        dec.sel = AMID_SEL_NONE;
      end
    endcase
  end
endmodule

// ### verilog/amid_wr_counter.sv
`timescale 1ns/10ps
`include "amid_defs.svh"
module amid_wr_counter (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic inc,
  input wire logic clr,
  output amid_pkg::amid_cnt_t count
);
  import amid_pkg::*;

  amid_cnt_t count_reg;
  amid_cnt_t count_next;

  // ====================================================================
  // Saturating count; an increment in the clearing cycle survives
  always_comb begin
    count_next = count_reg;
    if (clr) begin
      count_next = inc ? 16'h0001 : `AMID_CNT_RST;
    end else if (inc && count_reg != `AMID_CNT_MAX) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count_reg <= `AMID_CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule

// ### verilog/amid_regs.sv
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "amid_defs.svh"
module amid_regs (
  input wire logic ref_clk,
  input wire logic nrst,
  input amid_pkg::amid_addr_t reg_addr,
  input amid_pkg::amid_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output amid_pkg::amid_word_t reg_rdata
);
  import amid_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  amid_dec_if dec ();
  logic [1:0] ctrl_reg;
  logic last_id_wr_reg;
  amid_word_t rdata_reg;
  amid_word_t rdata_next;
  amid_cnt_t ign_count;
  logic clr_pulse;
  logic id_wr;

  // ====================================================================
  // Decode
  assign dec.addr = reg_addr;

  amid_id_rom u_rom (
    .dec(dec)
  );

  assign id_wr = reg_wr && dec.id_hit;
  assign clr_pulse = reg_wr && dec.sel == AMID_SEL_CTRL && reg_wdata[`AMID_CTRL_CLR_BIT];

  amid_wr_counter u_cnt (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inc(id_wr && ctrl_reg[`AMID_CTRL_EN_BIT]),
    .clr(clr_pulse),
    .count(ign_count)
  );

  // ====================================================================
  // Control: bit 1 enables counting, bit 0 clears (self-clearing)
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_reg <= `AMID_CTRL_RST;
    end else if (reg_wr && dec.sel == AMID_SEL_CTRL) begin
      ctrl_reg <= {reg_wdata[`AMID_CTRL_EN_BIT], 1'b0};
    end
  end

  // Remembers whether the latest write targeted an ID word
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      last_id_wr_reg <= 1'b0;
    end else if (reg_wr) begin
      last_id_wr_reg <= dec.id_hit;
    end
  end

  // ====================================================================
  // Read path
  always_comb begin
    rdata_next = `AMID_WORD_ZERO;
    if (reg_rd) begin
      unique case (dec.sel)
        AMID_SEL_CTRL: rdata_next = {30'h00000000, ctrl_reg};
        AMID_SEL_STAT: rdata_next = {15'h0000, last_id_wr_reg, ign_count};
        // ID words returned from the constant table
        default: rdata_next = dec.id_word;
      endcase
    end
  end

  // data valid only the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_reg <= `AMID_WORD_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ====================================================================
  // Checks
  // Reference words kept apart from the decoder, so a decode slip shows
  localparam amid_word_t REF_WORD [4] = '{
    32'h0000000D,
    32'h00000090,
    32'h00000005,
    32'h000000B1
  };

  amid_word_t ref_word;
  logic ref_hit;

  always_comb begin
    ref_word = `AMID_WORD_ZERO;
    ref_hit = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (reg_addr == `AMID_OFS_ID0 + 12'(4 * k)) begin
        ref_word = REF_WORD[k];
        ref_hit = 1'b1;
      end
    end
  end

  sequence rd_at(logic [11:0] a);
    reg_rd && reg_addr == a;
  endsequence

  sequence wr_id;
    reg_wr && ref_hit;
  endsequence

  sequence wr_other;
    reg_wr && !ref_hit;
  endsequence

  AST_ID1_CLASS: assert property (rd_at(`AMID_OFS_ID1) |=> reg_rdata[7:4] == 4'h9)
    else $error("class field wrong");
  AST_ID1_PRE: assert property (rd_at(`AMID_OFS_ID1) |=> reg_rdata[3:0] == 4'h0)
    else $error("low preamble not zero");
  AST_ID2_BYTE: assert property (rd_at(`AMID_OFS_ID2) |=> reg_rdata == 32'h00000005)
    else $error("byte two wrong");
  AST_ID3_BYTE: assert property (rd_at(`AMID_OFS_ID3) |=> reg_rdata == 32'h000000B1)
    else $error("byte three wrong");
  AST_ID0_BYTE: assert property (rd_at(`AMID_OFS_ID0) |=> reg_rdata == 32'h0000000D)
    else $error("byte zero wrong");
  for (genvar w = 0; w < 4; w++) begin : g_id_chk
    AST_ID_WORD: assert property (rd_at(`AMID_OFS_ID0 + 12'(4 * w))
        |=> reg_rdata == REF_WORD[w])
      else $error("identification word wrong");
  end
  AST_RSVD_ZERO: assert property (reg_rd && dec.id_hit |=> reg_rdata[31:8] == 24'h000000)
    else $error("reserved bits set");
  AST_ID_MAP: assert property (reg_rd && reg_addr[11:4] == 8'hFF && reg_addr[1:0] == 2'h0
      |=> reg_rdata != 32'h00000000)
    else $error("ID word missing");
  AST_WR_IGNORED: assert property (wr_id ##1 rd_at($past(reg_addr))
      |=> reg_rdata == $past(ref_word))
    else $error("ID word altered by write");
  AST_RD_ONCE: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outlived its cycle");
  AST_CNT_STEP: assert property (id_wr && ctrl_reg[`AMID_CTRL_EN_BIT] && !clr_pulse
      && ign_count != `AMID_CNT_MAX |=> ign_count == $past(ign_count) + 16'h0001)
    else $error("ignored write not counted");
  AST_CNT_HOLD: assert property (id_wr && !ctrl_reg[`AMID_CTRL_EN_BIT]
      |=> $stable(ign_count))
    else $error("count moved while disabled");
  AST_CNT_IDLE: assert property (!id_wr && !clr_pulse |=> $stable(ign_count))
    else $error("count moved without a write");
  AST_CNT_CLEAR: assert property (clr_pulse |=> ign_count == `AMID_CNT_RST)
    else $error("count not cleared");
  AST_LAST_SET: assert property (wr_id |=> last_id_wr_reg)
    else $error("ignored write not flagged");
  AST_LAST_CLR: assert property (wr_other |=> !last_id_wr_reg)
    else $error("flag kept after other write");
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
  import amid_pkg::*;
  // ==========================================================
  // Clock, reset and bus signals
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  amid_addr_t reg_addr = 12'h000;
  amid_word_t reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  amid_word_t reg_rdata;
  amid_word_t exp_q[$];
  logic rd_d = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  int seed = 91552;
  logic [7:0] id_val [4] = '{8'h0D, 8'h90, 8'h05, 8'hB1};
  always #2 ref_clk = ~ref_clk;
  amid_regs amid_regs_inst (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );
  // ==========================================================
  // Compare and verdict
  task automatic check(input amid_word_t seen, input amid_word_t want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && compares > 0 && exp_q.size() == 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================
  // Bus master; each task holds its strobe for exactly one edge
  task automatic acc(input logic r, input logic w, input amid_addr_t a, input amid_word_t d);
    reg_rd <= r;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input amid_addr_t a, input amid_word_t e);
    exp_q.push_back(e);
    acc(1'b1, 1'b0, a, 32'h00000000);
  endtask
  task automatic wr(input amid_addr_t a, input amid_word_t d);
    acc(1'b0, 1'b1, a, d);
  endtask
  task automatic idle(input int n);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  // ==========================================================
  // Monitor: data only in the cycle after a read, zero elsewhere
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      check(reg_rdata, exp_q.pop_front());
    end else begin
      check(reg_rdata, 32'h00000000);
    end
  end
  // ==========================================================
  // Watchdog; no scenario needs anywhere near this many cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end
  // ==========================================================
  // Scenarios
  initial begin
    int i;
    int j;
    amid_word_t d;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(12'hF00, 32'h00000002);
    rd(12'hF04, 32'h00000000);
    // Back-to-back reads of all identification words
    for (i = 0; i < 4; i++) begin
      rd(12'hFF0 + 12'(4 * i), {24'h000000, id_val[i]});
    end
    // Random writes to random words, each read straight after
    for (i = 0; i < 8; i++) begin
      j = $unsigned($random(seed)) % 4;
      d = $random(seed);
      wr(12'hFF0 + 12'(4 * j), d);
      rd(12'hFF0 + 12'(4 * j), {24'h000000, id_val[j]});
    end
    rd(12'hF04, 32'h00010008);
    // Unmapped and misaligned places read zero
    rd(12'h100, 32'h00000000);
    rd(12'hFF5, 32'h00000000);
    wr(12'h100, $random(seed));
    rd(12'hF04, 32'h00000008);
    // Clear the count, keep counting on
    wr(12'hF00, 32'h00000003);
    rd(12'hF00, 32'h00000002);
    rd(12'hF04, 32'h00000000);
    // Counting off: a word write is flagged, not counted
    wr(12'hF00, 32'h00000000);
    wr(12'hFF4, $random(seed));
    rd(12'hF00, 32'h00000000);
    rd(12'hF04, 32'h00010000);
    // Reset in mid-run drops the flag and re-enables counting, words still constant
    wr(12'hFFC, 32'hFFFFFFFF);
    idle(1);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(12'hF04, 32'h00000000);
    rd(12'hFFC, 32'h000000B1);
    rd(12'hF00, 32'h00000002);
    wr(12'hFF8, $random(seed));
    rd(12'hF04, 32'h00010001);
    idle(3);
    summarize();
  end
endmodule
